// ### rtl/alm_axis_limit_monitor.sv
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RULE1) Position is a signed 32-bit count of encoder increments.
// (RULE2) Passing either range end sets overrun flag; work area shifts 2^32.
// (RULE3) Overrun shows on monitoring status bit 2, 1 meaning active.
// (RULE4) Overrun stays set until a new referencing run or power cycle.
// (RULE5) Overrun allowed in every motion mode; targets use shifted area.
// (RULE6) Teach-in is refused while an overrun is recorded.
// (RULE7) Signed soft limits default to max and min; host keeps P above N.
// (RULE8) Soft limit enable bit 5 positive, bit 6 negative, both off at reset.
// (RULE9) Crossing an enabled soft limit sets status bit 5 or bit 6.
// (RULE10) Stop input forces quick stop; resume needs release, ack, command.
// (RULE11) Input enable bits: 0 pos, 1 neg limit, 2 stop, 3 home; reset 7.
// (RULE12) Polarity bits same layout; 0 reacts low, 1 reacts high; reset 0.
// (RULE13) Home switch optional for referencing; when enabled it acts as stop.
// (RULE14) Limit recovery only in manual; I/O mode 2 selects manual by input.
// (RULE15) Operator holds the opposite jog input until back inside travel.
// (RULE16) Active hardware limit blocks its direction; manual opposite allowed.
module alm_axis_limit_monitor
  import alm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [ALM_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [ALM_DATA_W-1:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [ALM_DATA_W-1:0] avsReadData,
  output logic avsWaitRequest,
  // Switches and sensors
  input wire logic positiveLimitInput,
  input wire logic negativeLimitInput,
  input wire logic stopInput,
  input wire logic homeSwitchInput,
  // Manual operation
  input wire logic autoManualSelectInput,
  input wire logic jogPositiveInput,
  input wire logic jogNegativeInput,
  // Motion core
  input wire logic encoderStep,
  input wire logic encoderDown,
  input wire logic moveCommand,
  input wire logic referenceDone,
  // Status outputs
  output logic [31:0] position,
  output logic quickStop,
  output logic motionEnable,
  output logic allowPositive,
  output logic allowNegative,
  output logic manualActive,
  output logic teachInAllowed,
  output logic irq
);

  alm_state_type s;
  alm_state_type next_s;

  logic [IN_NUM-1:0] rawIn;
  logic [IN_NUM-1:0] active;

  assign rawIn[IN_LIMIT_POS] = positiveLimitInput;
  assign rawIn[IN_LIMIT_NEG] = negativeLimitInput;
  assign rawIn[IN_STOP] = stopInput;
  assign rawIn[IN_HOME] = homeSwitchInput;

  // Per input qualification by enable and level
  genvar gi;
  generate
    for (gi = 0; gi < IN_NUM; gi = gi + 1)
    begin : gQualify
      assign active[gi] = s.inputMonitorEnable[gi] &
        (rawIn[gi] == s.inputMonitorPolarity[gi]); // [RULE11] [RULE12]
    end
  endgenerate

  // Byte-lane merge for register writes
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    logic wrEn;
    logic wrapUp;
    logic wrapDown;
    logic stopReq;
    logic ackWrite;
    logic posBlocked;
    logic negBlocked;
    logic manual;
    logic softPos;
    logic softNeg;
    logic [31:0] rd;
    logic [31:0] wd;
    logic [31:0] ctrlOld;
    logic [EV_W-1:0] evSet;
    logic [EV_W-1:0] evClr;
    wrEn = 1'b0;
    wrapUp = 1'b0;
    wrapDown = 1'b0;
    stopReq = 1'b0;
    ackWrite = 1'b0;
    posBlocked = 1'b0;
    negBlocked = 1'b0;
    manual = 1'b0;
    softPos = 1'b0;
    softNeg = 1'b0;
    rd = 32'h00000000;
    wd = 32'h00000000;
    ctrlOld = 32'h00000000;
    evSet = '0;
    evClr = '0;
    next_s = s;

    // Two-cycle access: waitrequest drops in the cycle after the request
    next_s.ack = (avsRead | avsWrite) & ~s.ack;
    wrEn = avsWrite & s.ack;

    ctrlOld[CTRL_MODE_LSB +: 3] = s.mode;
    ctrlOld[CTRL_IO_MODE_LSB +: 2] = s.ioMode;

    // Read mux; unmapped offsets read zero
    case (avsAddress)
      OFS_MONITORING_STATUS:
      begin
        rd[ST_OVERRUN_BIT] = s.overrun; // [RULE3]
        rd[ST_SOFT_POS_BIT] = s.softPosHit; // [RULE9]
        rd[ST_SOFT_NEG_BIT] = s.softNegHit; // [RULE9]
        rd[ST_QUICK_STOP_BIT] = (s.motion == MOT_STOPPED);
      end
      OFS_SOFT_LIMIT_POSITIVE: rd = s.softLimitPositive;
      OFS_SOFT_LIMIT_NEGATIVE: rd = s.softLimitNegative;
      OFS_SOFT_LIMIT_ENABLE: rd = {16'h0000, s.softLimitEnable};
      OFS_INPUT_MONITOR_ENABLE: rd = {16'h0000, s.inputMonitorEnable};
      OFS_INPUT_MONITOR_POLARITY: rd = {16'h0000, s.inputMonitorPolarity};
      OFS_CONTROL: rd = ctrlOld;
      OFS_POSITION: rd = s.position;
      OFS_EVENT_STATUS: rd[EV_W-1:0] = s.eventStatus;
      OFS_EVENT_MASK: rd[EV_W-1:0] = s.eventMask;
      OFS_WORK_AREA: rd = s.workArea;
      default: rd = 32'h00000000;
    endcase
    if (avsRead && !s.ack)
    begin
      next_s.readData = rd;
    end

    // Register writes take effect on the edge that completes the access
    if (wrEn)
    begin
      case (avsAddress)
        OFS_SOFT_LIMIT_POSITIVE:
        begin
          next_s.softLimitPositive = mergeBytes(s.softLimitPositive,
            avsWriteData, avsByteEnable); // [RULE7]
        end
        OFS_SOFT_LIMIT_NEGATIVE:
        begin
          next_s.softLimitNegative = mergeBytes(s.softLimitNegative,
            avsWriteData, avsByteEnable); // [RULE7]
        end
        OFS_SOFT_LIMIT_ENABLE:
        begin
          wd = mergeBytes({16'h0000, s.softLimitEnable}, avsWriteData,
            avsByteEnable);
          next_s.softLimitEnable = wd[15:0]; // [RULE8]
        end
        OFS_INPUT_MONITOR_ENABLE:
        begin
          wd = mergeBytes({16'h0000, s.inputMonitorEnable}, avsWriteData,
            avsByteEnable);
          next_s.inputMonitorEnable = wd[15:0]; // [RULE11]
        end
        OFS_INPUT_MONITOR_POLARITY:
        begin
          wd = mergeBytes({16'h0000, s.inputMonitorPolarity}, avsWriteData,
            avsByteEnable);
          next_s.inputMonitorPolarity = wd[15:0]; // [RULE12]
        end
        OFS_CONTROL:
        begin
          wd = mergeBytes(ctrlOld, avsWriteData, avsByteEnable);
          next_s.mode = wd[CTRL_MODE_LSB +: 3];
          next_s.ioMode = wd[CTRL_IO_MODE_LSB +: 2];
          // Ack bit is a strobe, never stored
          ackWrite = avsByteEnable[CTRL_ACK_BIT/8] &
            avsWriteData[CTRL_ACK_BIT];
        end
        OFS_EVENT_STATUS:
        begin
          evClr = avsWriteData[EV_W-1:0] & {EV_W{avsByteEnable[0]}};
        end
        OFS_EVENT_MASK:
        begin
          if (avsByteEnable[0])
          begin
            next_s.eventMask = avsWriteData[EV_W-1:0];
          end
        end
        default:
        begin
          wd = 32'h00000000;
        end
      endcase
    end

    // Position tracking; wrap is the 2^32 work area shift
    if (encoderStep)
    begin
      if (!encoderDown)
      begin
        next_s.position = s.position + 32'h00000001; // [RULE1]
        wrapUp = (s.position == POS_MAX);
      end
      else
      begin
        next_s.position = s.position - 32'h00000001; // [RULE1]
        wrapDown = (s.position == POS_MIN);
      end
    end
    // Wrap applies in any mode, so point targets land in the new area
    if (wrapUp)
    begin
      next_s.workArea = s.workArea + 32'h00000001; // [RULE2] [RULE5]
    end
    else if (wrapDown)
    begin
      next_s.workArea = s.workArea - 32'h00000001; // [RULE2] [RULE5]
    end

    // Referencing redefines the origin and ends the overrun
    if (referenceDone)
    begin
      next_s.position = 32'h00000000;
      next_s.workArea = 32'h00000000;
      next_s.overrun = 1'b0; // [RULE4]
    end
    // Set after clear so a wrap in the same cycle is not lost
    if (wrapUp || wrapDown)
    begin
      next_s.overrun = 1'b1; // [RULE2] [RULE4]
    end

    // Soft limit comparison on the current position
    softPos = s.softLimitEnable[SOFT_POSITIVE_LIMIT_BIT] &
      ($signed(s.position) > $signed(s.softLimitPositive)); // [RULE8] [RULE9]
    softNeg = s.softLimitEnable[SOFT_NEGATIVE_LIMIT_BIT] &
      ($signed(s.position) < $signed(s.softLimitNegative)); // [RULE8] [RULE9]
    next_s.softPosHit = softPos; // [RULE9]
    next_s.softNegHit = softNeg; // [RULE9]

    // Home switch doubles as stop only when enabled
    stopReq = active[IN_STOP] | active[IN_HOME]; // [RULE10] [RULE13]
    next_s.activePrev = active;

    // Quick stop sequence
    case (s.motion)
      MOT_RUN:
      begin
        if (stopReq)
        begin
          next_s.motion = MOT_STOPPED; // [RULE10]
          next_s.ackSeen = 1'b0;
        end
      end
      MOT_STOPPED:
      begin
        if (ackWrite)
        begin
          next_s.ackSeen = 1'b1;
        end
        // Ack may come before or after release; both are needed
        if (!stopReq && (s.ackSeen || ackWrite))
        begin
          next_s.motion = MOT_WAIT_CMD; // [RULE10]
        end
      end
      MOT_WAIT_CMD:
      begin
        if (stopReq)
        begin
          next_s.motion = MOT_STOPPED;
          next_s.ackSeen = 1'b0;
        end
        else if (moveCommand)
        begin
          next_s.motion = MOT_RUN; // [RULE10]
        end
      end
      default:
      begin
        next_s.motion = MOT_STOPPED;
        next_s.ackSeen = 1'b0;
      end
    endcase

    // Manual selection: by input under I/O mode 2, else by mode field
    if (s.ioMode == IO_MODE_SELECT_INPUT)
    begin
      manual = autoManualSelectInput; // [RULE14]
    end
    else
    begin
      manual = (s.mode == MODE_MANUAL); // [RULE14]
    end
    next_s.manualActive = manual;

    // Direction gating against limits
    posBlocked = active[IN_LIMIT_POS] | softPos; // [RULE16]
    negBlocked = active[IN_LIMIT_NEG] | softNeg; // [RULE16]
    // Leaving a tripped limit needs manual mode and the opposite jog
    next_s.allowPositive = (next_s.motion == MOT_RUN) & ~posBlocked &
      (~negBlocked | (manual & jogPositiveInput)); // [RULE14] [RULE15]
    next_s.allowNegative = (next_s.motion == MOT_RUN) & ~negBlocked &
      (~posBlocked | (manual & jogNegativeInput)); // [RULE14] [RULE15]

    // Sticky events; set wins over a simultaneous clear
    evSet[EV_OVERRUN] = wrapUp | wrapDown;
    evSet[EV_SOFT_POS] = softPos & ~s.softPosHit;
    evSet[EV_SOFT_NEG] = softNeg & ~s.softNegHit;
    evSet[EV_QUICK_STOP] = (s.motion != MOT_STOPPED) &
      (next_s.motion == MOT_STOPPED);
    evSet[EV_LIMIT_POS] = active[IN_LIMIT_POS] & ~s.activePrev[IN_LIMIT_POS];
    evSet[EV_LIMIT_NEG] = active[IN_LIMIT_NEG] & ~s.activePrev[IN_LIMIT_NEG];
    next_s.eventStatus = (s.eventStatus & ~evClr) | evSet;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s.ack <= 1'b0;
      s.readData <= 32'h00000000;
      s.position <= 32'h00000000;
      s.workArea <= 32'h00000000;
      s.overrun <= 1'b0;
      s.softLimitPositive <= RST_SOFT_LIMIT_POSITIVE; // [RULE7]
      s.softLimitNegative <= RST_SOFT_LIMIT_NEGATIVE; // [RULE7]
      s.softLimitEnable <= RST_SOFT_LIMIT_ENABLE; // [RULE8]
      s.inputMonitorEnable <= RST_INPUT_MONITOR_ENABLE; // [RULE11]
      s.inputMonitorPolarity <= RST_INPUT_MONITOR_POLARITY; // [RULE12]
      s.mode <= MODE_POINT;
      s.ioMode <= 2'h0;
      s.ackSeen <= 1'b0;
      s.motion <= MOT_WAIT_CMD;
      s.softPosHit <= 1'b0;
      s.softNegHit <= 1'b0;
      s.activePrev <= '0;
      s.eventStatus <= '0;
      s.eventMask <= '0;
      s.allowPositive <= 1'b0;
      s.allowNegative <= 1'b0;
      s.manualActive <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs
  assign avsWaitRequest = (avsRead | avsWrite) & ~s.ack;
  assign avsReadData = s.readData;
  assign position = s.position;
  assign quickStop = (s.motion == MOT_STOPPED); // [RULE10]
  assign motionEnable = (s.motion == MOT_RUN);
  assign allowPositive = s.allowPositive;
  assign allowNegative = s.allowNegative;
  assign manualActive = s.manualActive;
  // Stored teach positions mean nothing after a shift
  assign teachInAllowed = ~s.overrun; // [RULE6]
  assign irq = |(s.eventStatus & s.eventMask);

endmodule
`default_nettype wire

// ### rtl/alm_pkg.sv
package alm_pkg;
  // Bus geometry
  localparam int ALM_ADDR_W = 6;
  localparam int ALM_DATA_W = 32;
  // Register byte offsets
  localparam logic [5:0] OFS_MONITORING_STATUS = 6'h00;
  localparam logic [5:0] OFS_SOFT_LIMIT_POSITIVE = 6'h04;
  localparam logic [5:0] OFS_SOFT_LIMIT_NEGATIVE = 6'h08;
  localparam logic [5:0] OFS_SOFT_LIMIT_ENABLE = 6'h0c;
  localparam logic [5:0] OFS_INPUT_MONITOR_ENABLE = 6'h10;
  localparam logic [5:0] OFS_INPUT_MONITOR_POLARITY = 6'h14;
  localparam logic [5:0] OFS_CONTROL = 6'h18;
  localparam logic [5:0] OFS_POSITION = 6'h1c;
  localparam logic [5:0] OFS_EVENT_STATUS = 6'h20;
  localparam logic [5:0] OFS_EVENT_MASK = 6'h24;
  localparam logic [5:0] OFS_WORK_AREA = 6'h28;
  // Monitoring status bits
  localparam int ST_OVERRUN_BIT = 2;
  localparam int ST_SOFT_POS_BIT = 5;
  localparam int ST_SOFT_NEG_BIT = 6;
  localparam int ST_QUICK_STOP_BIT = 8;
  // Soft limit enable bits
  localparam int SOFT_POSITIVE_LIMIT_BIT = 5;
  localparam int SOFT_NEGATIVE_LIMIT_BIT = 6;
  // Monitored input bit positions
  localparam int IN_NUM = 4;
  localparam int IN_LIMIT_POS = 0;
  localparam int IN_LIMIT_NEG = 1;
  localparam int IN_STOP = 2;
  localparam int IN_HOME = 3;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_IO_MODE_LSB = 4;
  localparam int CTRL_ACK_BIT = 16;
  // Operating modes and I/O mode
  localparam logic [2:0] MODE_POINT = 3'h0;
  localparam logic [2:0] MODE_SPEED = 3'h1;
  localparam logic [2:0] MODE_GEAR = 3'h2;
  localparam logic [2:0] MODE_REFERENCE = 3'h3;
  localparam logic [2:0] MODE_MANUAL = 3'h4;
  localparam logic [1:0] IO_MODE_SELECT_INPUT = 2'h2;
  // Event bits
  localparam int EV_W = 6;
  localparam int EV_OVERRUN = 0;
  localparam int EV_SOFT_POS = 1;
  localparam int EV_SOFT_NEG = 2;
  localparam int EV_QUICK_STOP = 3;
  localparam int EV_LIMIT_POS = 4;
  localparam int EV_LIMIT_NEG = 5;
  // Reset values and range ends
  localparam logic [31:0] RST_SOFT_LIMIT_POSITIVE = 32'h7fffffff;
  localparam logic [31:0] RST_SOFT_LIMIT_NEGATIVE = 32'h80000000;
  localparam logic [15:0] RST_SOFT_LIMIT_ENABLE = 16'h0000;
  localparam logic [15:0] RST_INPUT_MONITOR_ENABLE = 16'h0007;
  localparam logic [15:0] RST_INPUT_MONITOR_POLARITY = 16'h0000;
  localparam logic [31:0] POS_MAX = 32'h7fffffff;
  localparam logic [31:0] POS_MIN = 32'h80000000;
  typedef enum logic [1:0] {MOT_RUN, MOT_STOPPED, MOT_WAIT_CMD}
    alm_motion_type;
  typedef struct packed {
    logic ack;
    logic [31:0] readData;
    logic [31:0] position;
    logic [31:0] workArea;
    logic overrun;
    logic [31:0] softLimitPositive;
    logic [31:0] softLimitNegative;
    logic [15:0] softLimitEnable;
    logic [15:0] inputMonitorEnable;
    logic [15:0] inputMonitorPolarity;
    logic [2:0] mode;
    logic [1:0] ioMode;
    logic ackSeen;
    alm_motion_type motion;
    logic softPosHit;
    logic softNegHit;
    logic [IN_NUM-1:0] activePrev;
    logic [EV_W-1:0] eventStatus;
    logic [EV_W-1:0] eventMask;
    logic allowPositive;
    logic allowNegative;
    logic manualActive;
  } alm_state_type;
endpackage

// ### verif/alm_field_model.sv
`timescale 1ns/1ps
`default_nettype none
module alm_field_model
(
  // Operator and machine actions
  input wire logic tripPos,
  input wire logic tripNeg,
  input wire logic stopPress,
  input wire logic homePress,
  input wire logic manSel,
  input wire logic jogPos,
  input wire logic jogNeg,
  // Pins
  output logic positiveLimitInput,
  output logic negativeLimitInput,
  output logic stopInput,
  output logic homeSwitchInput,
  output logic autoManualSelectInput,
  output logic jogPositiveInput,
  output logic jogNegativeInput
);
  // Switches open on trip: wired so that a broken wire also reads active
  assign positiveLimitInput = !tripPos;
  assign negativeLimitInput = !tripNeg;
  assign stopInput = !stopPress;
  assign homeSwitchInput = !homePress;
  assign autoManualSelectInput = manSel;
  // Operator holds only the jog leading away from a tripped switch
  assign jogPositiveInput = jogPos && !tripPos;
  assign jogNegativeInput = jogNeg && !tripNeg;
endmodule
`default_nettype wire

// ### verif/alm_limit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module alm_limit_monitor
  import alm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic [ALM_ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [ALM_DATA_W-1:0] avsReadData,
  input wire logic avsWaitRequest,
  // Motion core
  input wire logic encoderStep,
  input wire logic encoderDown,
  input wire logic moveCommand,
  input wire logic referenceDone,
  // Status
  input wire logic [31:0] position,
  input wire logic quickStop,
  input wire logic motionEnable,
  input wire logic teachInAllowed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  stop_excl_a: assert property (quickStop |-> !motionEnable)
    else $error("motion enabled during quick stop");
  resume_cmd_a: assert property ($rose(motionEnable) |->
    $past(moveCommand))
    else $error("motion resumed without a command");
  teach_fall_a: assert property ($fell(teachInAllowed) |->
    ($past(position) == POS_MAX && position == POS_MIN) ||
    ($past(position) == POS_MIN && position == POS_MAX))
    else $error("teach-in refused without a range wrap");
  teach_rise_a: assert property ($rose(teachInAllowed) |->
    $past(referenceDone))
    else $error("overrun cleared without referencing");
  pos_hold_a: assert property ((position != $past(position)) |->
    $past(encoderStep) || $past(referenceDone))
    else $error("position moved without an increment");
  step_up_a: assert property ($past(encoderStep) &&
    !$past(encoderDown) && !$past(referenceDone) |->
    position == $past(position) + 32'h1)
    else $error("position did not count up by one");
  one_wait_a: assert property ((avsRead || avsWrite) &&
    avsWaitRequest |=> !avsWaitRequest)
    else $error("bus answer not after one wait cycle");
  unmapped_a: assert property (avsRead && !avsWaitRequest &&
    avsAddress == 6'h3c |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (avsRead && !avsWaitRequest &&
    avsAddress == OFS_SOFT_LIMIT_ENABLE |-> avsReadData[31:16] == 16'h0)
    else $error("upper half of enable register not zero");
endmodule
bind alm_axis_limit_monitor alm_limit_monitor alm_limit_monitor_inst (.clk,
  .rst, .avsAddress, .avsRead, .avsWrite, .avsReadData, .avsWaitRequest,
  .encoderStep, .encoderDown, .moveCommand, .referenceDone, .position,
  .quickStop, .motionEnable, .teachInAllowed);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import alm_pkg::*;
;
  logic clk, rst, avsRead, avsWrite, avsWaitRequest, encoderStep, encoderDown;
  logic moveCommand, referenceDone, quickStop, motionEnable, allowPositive;
  logic allowNegative, manualActive, teachInAllowed, irq;
  logic posL, negL, stopL, homeL, amSel, jogP, jogN;
  logic tripPos, tripNeg, stopPress, homePress, manSel, jogPos, jogNeg;
  logic [5:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, position, d;
  logic [3:0] avsByteEnable;
  int errors, cmp_count;
  logic [5:0] ta [7] = '{OFS_SOFT_LIMIT_POSITIVE, OFS_SOFT_LIMIT_NEGATIVE,
    OFS_SOFT_LIMIT_ENABLE, OFS_INPUT_MONITOR_ENABLE,
    OFS_INPUT_MONITOR_POLARITY, OFS_MONITORING_STATUS, 6'h3c};
  logic [31:0] te [7] = '{32'h7fffffff, 32'h80000000, 32'h0, 32'h7, 32'h0,
    32'h0, 32'h0};
  alm_axis_limit_monitor alm_axis_limit_monitor_inst (.clk, .rst,
    .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .positiveLimitInput(posL),
    .negativeLimitInput(negL), .stopInput(stopL), .homeSwitchInput(homeL),
    .autoManualSelectInput(amSel), .jogPositiveInput(jogP),
    .jogNegativeInput(jogN), .encoderStep, .encoderDown, .moveCommand,
    .referenceDone, .position, .quickStop, .motionEnable, .allowPositive,
    .allowNegative, .manualActive, .teachInAllowed, .irq);
  alm_field_model alm_field_model_inst (.tripPos, .tripNeg, .stopPress,
    .homePress, .manSel, .jogPos, .jogNeg, .positiveLimitInput(posL),
    .negativeLimitInput(negL), .stopInput(stopL), .homeSwitchInput(homeL),
    .autoManualSelectInput(amSel), .jogPositiveInput(jogP),
    .jogNegativeInput(jogN));
  initial
  begin
    clk = 0;
    forever #50 clk = !clk;
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    @(posedge clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= wd;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (avsWaitRequest === 1'b0)
        break;
    end
    if (n == 20)
    begin
      errors++;
      $display("[FAIL] bus answer expected waitrequest low seen high");
      wrap_up();
    end
    rd = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic pulse_move();
    @(posedge clk);
    moveCommand <= 1'b1;
    @(posedge clk);
    moveCommand <= 1'b0;
  endtask
  task automatic steps(input int n, input logic dn);
    repeat (n)
    begin
      @(posedge clk);
      encoderStep <= 1'b1;
      encoderDown <= dn;
      @(posedge clk);
      encoderStep <= 1'b0;
    end
  endtask
  initial
  begin
    {avsRead, avsWrite, encoderStep, encoderDown, moveCommand} = '0;
    {referenceDone, tripPos, tripNeg, stopPress, homePress} = '0;
    {manSel, jogPos, jogNeg} = '0;
    avsAddress = '0;
    avsWriteData = '0;
    avsByteEnable = 4'hf;
    errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ta[i], 32'h0, d);
      chk("reset value", te[i], d);
    end
    chk("teachIn", 32'h1, {31'h0, teachInAllowed});
    pulse_move();
    settle(1);
    chk("run", 32'h1, {31'h0, motionEnable});
    wr(OFS_SOFT_LIMIT_POSITIVE, 32'h3);
    wr(OFS_SOFT_LIMIT_ENABLE, 32'h20);
    wr(OFS_EVENT_MASK, 32'h2);
    steps(5, 1'b0);
    settle(2);
    chk("position", 32'h5, position);
    bus(1'b0, OFS_MONITORING_STATUS, 32'h0, d);
    chk("soft pos bit", 32'h20, d & 32'h64);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFS_EVENT_STATUS, 32'h2);
    settle(1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(OFS_SOFT_LIMIT_NEGATIVE, 32'hfffffffe);
    wr(OFS_SOFT_LIMIT_ENABLE, 32'h60);
    steps(9, 1'b1);
    settle(2);
    chk("position", 32'hfffffffc, position);
    bus(1'b0, OFS_MONITORING_STATUS, 32'h0, d);
    chk("soft neg bit", 32'h40, d & 32'h64);
    stopPress <= 1'b1;
    settle(2);
    chk("quick stop", 32'h1, {31'h0, quickStop});
    pulse_move();
    settle(1);
    chk("move refused", 32'h0, {31'h0, motionEnable});
    @(posedge clk);
    stopPress <= 1'b0;
    settle(2);
    chk("stop held", 32'h1, {31'h0, quickStop});
    wr(OFS_CONTROL, 32'h10000);
    settle(1);
    chk("stop acked", 32'h0, {31'h0, quickStop});
    pulse_move();
    settle(1);
    chk("resumed", 32'h1, {31'h0, motionEnable});
    // Idle high stop line becomes active once it reacts at high level
    wr(OFS_INPUT_MONITOR_POLARITY, 32'h4);
    settle(2);
    chk("high polarity", 32'h1, {31'h0, quickStop});
    @(posedge clk);
    stopPress <= 1'b1;
    wr(OFS_CONTROL, 32'h10000);
    settle(1);
    chk("low ignored", 32'h0, {31'h0, quickStop});
    wr(OFS_INPUT_MONITOR_POLARITY, 32'h0);
    stopPress <= 1'b0;
    wr(OFS_INPUT_MONITOR_ENABLE, 32'hf);
    homePress <= 1'b1;
    settle(2);
    chk("home stop", 32'h1, {31'h0, quickStop});
    @(posedge clk);
    homePress <= 1'b0;
    wr(OFS_CONTROL, 32'h10000);
    // Soft limits off so only the switch gates direction
    wr(OFS_SOFT_LIMIT_ENABLE, 32'h0);
    pulse_move();
    settle(1);
    chk("pos free", 32'h1, {31'h0, allowPositive});
    @(posedge clk);
    tripPos <= 1'b1;
    settle(2);
    chk("pos blocked", 32'h0, {31'h0, allowPositive});
    chk("neg auto", 32'h0, {31'h0, allowNegative});
    wr(OFS_CONTROL, 32'h20);
    manSel <= 1'b1;
    jogNeg <= 1'b1;
    settle(2);
    chk("manual", 32'h1, {31'h0, manualActive});
    chk("neg jog", 32'h1, {31'h0, allowNegative});
    chk("pos still", 32'h0, {31'h0, allowPositive});
    bus(1'b0, OFS_EVENT_STATUS, 32'h0, d);
    chk("limit event", 32'h10, d & 32'h10);
    wrap_up();
  end
endmodule
`default_nettype wire
